// >>> qup_host_pins.sv
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Outside loopback each channel shows its inverted modem-ready pin level in its modem-status register.
// - Modem-ready never affects transmitter or receiver; it feeds status and the modem-change interrupt only.
// - Terminal-ready output is low while modem-control terminal-ready bit is set and loopback is off.
// - Terminal-ready goes high on reset, in loopback, or when bit 0 cleared.
// - One shared override input acts on all four interrupt outputs with bit 3.
// - Override low: each interrupt output enabled by its auxiliary-output-two bit.
// - Override low: bit 3 clear floats the interrupt pin, set drives it.
// - Override high: every interrupt output driven regardless of bit 3.
// - Interrupt output goes high when an enabled source is pending.
// - Four sources: receiver error, receive data, transmit empty, modem change.
// - Pending interrupt withdrawn when serviced, and cleared by reset.
// - A read returns the addressed register of the selected channel.
// - A write loads the bus data into the addressed register; writes to the line- and modem-status registers are ignored.
// - Reset clears most registers and forces outputs to reset states.
// - During reset the serial output and input are disabled.
// - A channel takes accesses only when it is the selected channel.
// - Three address bits pick the register within the channel.
// - Every serial transmit output goes marking (high) on reset.
module qup_host_pins
  import qup_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire qup_av_req_s          av_req_i,
  output logic [7:0]                av_readdata_o,
  output logic                      av_waitrequest_o,
  input  wire logic [NCH-1:0]       modem_ready_in_n_i,
  output logic [NCH-1:0]            terminal_ready_out_n_o,
  input  wire logic                 irq_force_enable_i,
  output logic [NCH-1:0]            channel_irq_out_o,
  output logic [NCH-1:0]            channel_irq_oe_n_o,
  output logic [NCH-1:0]            serial_tx_out_o,
  input  wire logic [NCH-1:0]       serial_rx_in_i,
  output logic [NCH-1:0]            rx_line_o,
  input  wire logic [NCH-1:0][7:0]  rx_data_i,
  input  wire logic [NCH-1:0]       rx_avail_i,
  input  wire logic [NCH-1:0]       rx_error_i,
  output logic [NCH-1:0]            rx_pop_o,
  output logic [NCH-1:0][7:0]       tx_data_o,
  output logic [NCH-1:0]            tx_load_o,
  input  wire logic [NCH-1:0]       tx_done_i
);

  // ************************************************************
  // Helpers.
  // ************************************************************

  // Highest-priority pending source, as the identity register shows it.
  function automatic logic [3:0] iir_code(input qup_chan_s c, input logic rxa);
    logic [3:0] en;
    en = c.ier[3:0];
    if (en[2] && c.lsr_err) iir_code = IIR_LSR;
    else if (en[0] && rxa) iir_code = IIR_RXA;
    else if (en[1] && c.thre) iir_code = IIR_THRE;
    else if (en[3] && c.ddsr) iir_code = IIR_MSR;
    else iir_code = IIR_NONE;
  endfunction

  qup_state_s s_q;
  qup_state_s s_d;
  logic       req;

  // One wait cycle per access keeps the read mux off the bus path.
  assign req              = av_req_i.read | av_req_i.write;
  assign av_waitrequest_o = req & ~s_q.ack;

  // ************************************************************
  // Next state.
  // ************************************************************

  // Each channel's bus effects, status flags and pin levels.
  always_comb begin
    logic [2:0] ra;
    logic       sel;
    logic       wr;
    logic       rd;
    logic       loop;
    logic       dsr_now;
    qup_chan_s  c;
    ra      = av_req_i.address[2:0];
    sel     = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    loop    = 1'b0;
    dsr_now = 1'b0;
    c       = CH_RST;
    s_d     = s_q;
    s_d.ack = req & ~s_q.ack;
    s_d.rdata = s_q.rdata;
    for (int i = 0; i < NCH; i++) begin
      c       = s_q.ch[i];
      sel     = s_q.ack && (av_req_i.address[4:3] == 2'(i));
      wr      = sel & av_req_i.write;
      rd      = sel & av_req_i.read;
      loop    = c.mctl[MCTL_LOOP];
      // In loopback the modem-ready status follows the terminal-ready bit.
      dsr_now = loop ? c.mctl[MCTL_TRDY] : ~modem_ready_in_n_i[i];
      s_d.ch[i].dsr     = dsr_now;
      s_d.ch[i].tx_load = 1'b0;
      s_d.ch[i].rx_pop  = 1'b0;
      // Clears come first so that a coinciding event still sets the flag.
      if (rd && ra == OFF_MSR) s_d.ch[i].ddsr = 1'b0;
      if (dsr_now != c.dsr) s_d.ch[i].ddsr = 1'b1;
      if (rd && ra == OFF_LSR) s_d.ch[i].lsr_err = 1'b0;
      if (rx_error_i[i]) s_d.ch[i].lsr_err = 1'b1;
      if (rd && ra == OFF_IIR && iir_code(c, rx_avail_i[i]) == IIR_THRE) s_d.ch[i].thre = 1'b0;
      if (wr && ra == OFF_DATA) s_d.ch[i].thre = 1'b0;
      if (tx_done_i[i]) s_d.ch[i].thre = 1'b1;
      if (rd && ra == OFF_DATA) s_d.ch[i].rx_pop = 1'b1;
      if (wr) begin
        case (ra)
          OFF_DATA: begin
            s_d.ch[i].txd     = av_req_i.writedata;
            s_d.ch[i].tx_load = 1'b1;
          end
          OFF_IER: s_d.ch[i].ier = {4'h0, av_req_i.writedata[3:0]};
          OFF_IIR: s_d.ch[i].fifo_en = av_req_i.writedata[FCR_EN];
          OFF_LCR: s_d.ch[i].lcr = av_req_i.writedata;
          OFF_MCTL: s_d.ch[i].mctl = {3'h0, av_req_i.writedata[4:0]};
          OFF_SCR: s_d.ch[i].scr = av_req_i.writedata;
          default: s_d.ch[i].ier = c.ier;
        endcase
      end
      // Idle marking unless a break is forced; loopback keeps the pin marking.
      s_d.ch[i].tx = loop | ~c.lcr[LCR_BRK];
      s_d.ch[i].rx = loop ? ~c.lcr[LCR_BRK] : serial_rx_in_i[i];
      s_d.ch[i].dtr_n = ~(c.mctl[MCTL_TRDY] & ~loop);
      s_d.ch[i].irq = iir_code(c, rx_avail_i[i]) != IIR_NONE;
      s_d.ch[i].irq_oe_n = ~(irq_force_enable_i | c.mctl[MCTL_AUX2]);
    end
    // Register data is captured when the request is first seen.
    if (req && !s_q.ack && av_req_i.read) begin
      c = s_q.ch[av_req_i.address[4:3]];
      case (ra)
        OFF_DATA: s_d.rdata = rx_data_i[av_req_i.address[4:3]];
        OFF_IER:  s_d.rdata = c.ier;
        OFF_IIR:  s_d.rdata = {{2{c.fifo_en}}, 2'b00, iir_code(c, rx_avail_i[av_req_i.address[4:3]])};
        OFF_LCR:  s_d.rdata = c.lcr;
        OFF_MCTL: s_d.rdata = c.mctl;
        OFF_LSR:  s_d.rdata = {2'b00, c.thre, 3'b000, c.lsr_err, rx_avail_i[av_req_i.address[4:3]]};
        OFF_MSR:  s_d.rdata = {2'b00, c.dsr, 3'b000, c.ddsr, 1'b0};
        OFF_SCR:  s_d.rdata = c.scr;
        default:  s_d.rdata = REG_RST;
      endcase
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************

  // Reset holds every channel at its defined state, serial pins idle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q.ch    <= {NCH{CH_RST}};
      s_q.ack   <= 1'b0;
      s_q.rdata <= REG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************

  // The modem-ready level reaches only the status register and the modem-change interrupt, never the serial paths.
  assign av_readdata_o = s_q.rdata;
  for (genvar g = 0; g < NCH; g++) begin : g_out
    assign terminal_ready_out_n_o[g] = s_q.ch[g].dtr_n;
    assign channel_irq_out_o[g]      = s_q.ch[g].irq;
    assign channel_irq_oe_n_o[g]     = s_q.ch[g].irq_oe_n;
    assign serial_tx_out_o[g]        = s_q.ch[g].tx;
    assign rx_line_o[g]              = s_q.ch[g].rx;
    assign rx_pop_o[g]               = s_q.ch[g].rx_pop;
    assign tx_data_o[g]              = s_q.ch[g].txd;
    assign tx_load_o[g]              = s_q.ch[g].tx_load;
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence acc_start;
    req && !s_q.ack;
  endsequence

  sequence acc_done;
    s_q.ack && req;
  endsequence

  wait_once_a: assert property (acc_start |-> av_waitrequest_o ##1 !av_waitrequest_o)
    else $error("access not answered after one wait cycle");

  rd_scr_a: assert property ((acc_start and av_req_i.read && av_req_i.address[2:0] == OFF_SCR)
      |=> av_readdata_o == $past(s_q.ch[av_req_i.address[4:3]].scr))
    else $error("scratch read returned wrong data");

  wr_scr_a: assert property ((acc_done and av_req_i.write && av_req_i.address[2:0] == OFF_SCR)
      |=> s_q.ch[$past(av_req_i.address[4:3])].scr == $past(av_req_i.writedata))
    else $error("scratch write not stored");

  tx_mark_a: assert property (@(posedge clk_i) disable iff (1'b0)
      !rst_n_i |=> &serial_tx_out_o && &terminal_ready_out_n_o && &channel_irq_oe_n_o)
    else $error("outputs not at reset state after reset");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    dtr_on_a: assert property ((acc_done and av_req_i.write && av_req_i.address == {2'(g), OFF_MCTL}
        && av_req_i.writedata[MCTL_TRDY] && !av_req_i.writedata[MCTL_LOOP])
        |=> ##1 !terminal_ready_out_n_o[g])
      else $error("terminal ready not driven low");
    dtr_off_a: assert property ((acc_done and av_req_i.write && av_req_i.address == {2'(g), OFF_MCTL}
        && (!av_req_i.writedata[MCTL_TRDY] || av_req_i.writedata[MCTL_LOOP]))
        |=> ##1 terminal_ready_out_n_o[g])
      else $error("terminal ready not released");
    irq_force_a: assert property (irq_force_enable_i |=> !channel_irq_oe_n_o[g])
      else $error("forced interrupt output not driven");
    irq_float_a: assert property ((!irq_force_enable_i && !s_q.ch[g].mctl[MCTL_AUX2])
        |=> channel_irq_oe_n_o[g])
      else $error("interrupt output driven while disabled");
    dsr_seen_a: assert property (($changed(modem_ready_in_n_i[g]) && !s_q.ch[g].mctl[MCTL_LOOP])
        |=> s_q.ch[g].ddsr && s_q.ch[g].dsr == !$past(modem_ready_in_n_i[g]))
      else $error("modem-ready change not reported");
    irq_thre_a: assert property ((s_q.ch[g].ier[1] && s_q.ch[g].thre) |=> channel_irq_out_o[g])
      else $error("enabled pending source gave no interrupt");
    lsr_clr_a: assert property ((acc_done and av_req_i.read && av_req_i.address == {2'(g), OFF_LSR}
        && !rx_error_i[g]) |=> !s_q.ch[g].lsr_err)
      else $error("error flag not cleared by status read");
  end

endmodule

// >>> qup_pkg.sv
package qup_pkg;

  // ************************************************************
  // Sizes and register offsets.
  // ************************************************************
  localparam int          NCH      = 4;
  localparam logic [2:0]  OFF_DATA = 3'h0;
  localparam logic [2:0]  OFF_IER  = 3'h1;
  localparam logic [2:0]  OFF_IIR  = 3'h2;
  localparam logic [2:0]  OFF_LCR  = 3'h3;
  localparam logic [2:0]  OFF_MCTL = 3'h4;
  localparam logic [2:0]  OFF_LSR  = 3'h5;
  localparam logic [2:0]  OFF_MSR  = 3'h6;
  localparam logic [2:0]  OFF_SCR  = 3'h7;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int MCTL_TRDY = 0;
  localparam int MCTL_AUX2 = 3;
  localparam int MCTL_LOOP = 4;
  localparam int LCR_BRK  = 6;
  localparam int FCR_EN   = 0;
  localparam int LSR_DR   = 0;
  localparam int LSR_ERR  = 1;
  localparam int LSR_THRE = 5;
  localparam int MSTAT_DMRDY = 1;
  localparam int MSTAT_MRDY  = 5;

  // ************************************************************
  // Interrupt identity codes and reset values.
  // ************************************************************
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LSR  = 4'h6;
  localparam logic [3:0] IIR_RXA  = 4'h4;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [3:0] IIR_MSR  = 4'h0;
  localparam logic [7:0] REG_RST  = 8'h00;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [4:0] address;
    logic [7:0] writedata;
  } qup_av_req_s;

  typedef struct packed {
    logic [7:0] ier;
    logic [7:0] lcr;
    logic [7:0] mctl;
    logic [7:0] scr;
    logic [7:0] txd;
    logic       fifo_en;
    logic       thre;
    logic       lsr_err;
    logic       ddsr;
    logic       dsr;
    logic       tx;
    logic       rx;
    logic       dtr_n;
    logic       irq;
    logic       irq_oe_n;
    logic       tx_load;
    logic       rx_pop;
  } qup_chan_s;

  typedef struct packed {
    qup_chan_s [NCH-1:0] ch;
    logic                ack;
    logic [7:0]          rdata;
  } qup_state_s;

  localparam qup_chan_s CH_RST = '{ier: REG_RST, lcr: REG_RST, mctl: REG_RST, scr: REG_RST,
                                   txd: REG_RST, thre: 1'b1, tx: 1'b1, rx: 1'b1, dtr_n: 1'b1,
                                   irq_oe_n: 1'b1, default: 1'b0};

endpackage

// >>> qup_modem_model.sv
`timescale 1ns/1ps
module qup_modem_model
  import qup_pkg::*;
#(
  parameter int TX_DELAY = 5
) (
  input  wire logic                clk_i,
  input  wire logic [NCH-1:0]      ready_i,
  input  wire logic [NCH-1:0]      byte_req_i,
  input  wire logic [NCH-1:0]      err_req_i,
  input  wire logic [NCH-1:0]      rx_pop_i,
  input  wire logic [NCH-1:0]      tx_load_i,
  output logic [NCH-1:0]           modem_ready_in_n_o,
  output logic [NCH-1:0]           serial_rx_o,
  output logic [NCH-1:0]           rx_avail_o,
  output logic [NCH-1:0]           rx_error_o,
  output logic [NCH-1:0]           tx_done_o,
  output logic [NCH-1:0][7:0]      rx_data_o
);
  logic [7:0]           spin_q = 8'h5A;
  logic [NCH-1:0][3:0]  tx_cnt_q = '0;

  // The idle serial line rests at marking, as a pulled-up input would.
  assign serial_rx_o = '1;

  // With no byte held the data lines churn, so a stale byte never reads as valid.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rx_data_o[i] = rx_avail_o[i] ? 8'(8'hC0 + i) : (spin_q ^ 8'(i));
    end
  end

  // Outputs start idle; the model has no reset of its own.
  initial begin
    modem_ready_in_n_o = '1;
    rx_avail_o = '0;
    rx_error_o = '0;
    tx_done_o = '0;
  end

  // Modem pin, receive events and a transmitter that finishes a fixed time after each load.
  always @(posedge clk_i) begin
    spin_q <= spin_q + 8'h01;
    for (int i = 0; i < NCH; i++) begin
      modem_ready_in_n_o[i] <= ~ready_i[i];
      rx_error_o[i] <= err_req_i[i];
      if (byte_req_i[i]) begin
        rx_avail_o[i] <= 1'b1;
      end else if (rx_pop_i[i]) begin
        rx_avail_o[i] <= 1'b0;
      end
      if (tx_load_i[i]) begin
        tx_cnt_q[i] <= 4'(TX_DELAY);
      end else if (tx_cnt_q[i] != 4'h0) begin
        tx_cnt_q[i] <= tx_cnt_q[i] - 4'h1;
      end
      tx_done_o[i] <= (tx_cnt_q[i] == 4'h1);
    end
  end
endmodule

// >>> qup_host_pins_bench.sv
`timescale 1ns/1ps
module qup_host_pins_bench
  import qup_pkg::*;
();
  logic                 clk, rst_n, force_en, wait_req;
  qup_av_req_s          req;
  logic [7:0]           rdata, q, v;
  logic [NCH-1:0]       rdy_n, dtr_n, irq, oe_n, tx, rx_in, rx_line, avail, err, pop, load, done;
  logic [NCH-1:0]       ready, byte_req, err_req, aux;
  logic [NCH-1:0][7:0]  rxd, txd, scr;
  int                   mismatches, checks_done;

  qup_host_pins DUT (.clk_i(clk), .rst_n_i(rst_n), .av_req_i(req), .av_readdata_o(rdata),
    .av_waitrequest_o(wait_req), .modem_ready_in_n_i(rdy_n), .terminal_ready_out_n_o(dtr_n),
    .irq_force_enable_i(force_en), .channel_irq_out_o(irq), .channel_irq_oe_n_o(oe_n),
    .serial_tx_out_o(tx), .serial_rx_in_i(rx_in), .rx_line_o(rx_line), .rx_data_i(rxd),
    .rx_avail_i(avail), .rx_error_i(err), .rx_pop_o(pop), .tx_data_o(txd), .tx_load_o(load),
    .tx_done_i(done));
  qup_modem_model #(.TX_DELAY(5)) modem (.clk_i(clk), .ready_i(ready), .byte_req_i(byte_req),
    .err_req_i(err_req), .rx_pop_i(pop), .tx_load_i(load), .modem_ready_in_n_o(rdy_n),
    .serial_rx_o(rx_in), .rx_avail_o(avail), .rx_error_o(err), .tx_done_o(done), .rx_data_o(rxd));

  // ****************
  // Clock and helpers.
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One bus access; an edge passes first so the request never toggles within one step.
  task automatic acc(input logic wr, input int c, input logic [2:0] off, input logic [7:0] d);
    int n;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: {c[1:0], off}, writedata: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
    q = rdata;
    req <= '0;
  endtask

  task automatic see_irq(input logic on, input int c);
    tick(5);
    chk("irq", {4'h0, irq}, on ? {4'h0, 4'h1 << c} : 8'h00);
  endtask

  function automatic logic [7:0] oe_vec(input logic f, input logic [3:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NCH; i++) r[i] = !(f | a[i]);
    return r;
  endfunction

  // ****************
  // Main sequence.
  // ****************
  initial begin
    {req, force_en, ready, byte_req, err_req, aux, rst_n} = '0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(32'hDEF9));
    tick(3);
    chk("reset_pins", {dtr_n, oe_n}, 8'hFF);
    chk("reset_lines", {tx, rx_line}, 8'hFF);
    rst_n <= 1'b1;
    for (int c = 0; c < NCH; c++) begin
      v = 8'($urandom);
      acc(1'b1, c, OFF_SCR, v);
      acc(1'b0, c, OFF_SCR, 8'h00);
      chk("scratch", q, v);
      scr[c] = v;
      acc(1'b1, c, OFF_MCTL, 8'h01);
      tick(3);
      chk("dtr", {4'h0, dtr_n}, {4'h0, ~(4'h1 << c)});
      acc(1'b1, c, OFF_MCTL, 8'h11);
      tick(3);
      chk("dtr_loop", {4'h0, dtr_n}, 8'h0F);
      chk("rx_loop", {4'h0, rx_line}, 8'h0F);
      for (int k = 0; k < 4; k++) begin
        force_en <= k[1];
        aux[c] = k[0];
        acc(1'b1, c, OFF_MCTL, {4'h0, k[0], 3'h0});
        tick(3);
        chk("irq_oe_n", {4'h0, oe_n}, oe_vec(k[1], aux));
      end
      force_en <= 1'b0;
      acc(1'b1, c, OFF_IER, 8'h02);
      see_irq(1'b1, c);
      acc(1'b0, c, OFF_IIR, 8'h00);
      chk("iir_thre", q, {4'h0, IIR_THRE});
      see_irq(1'b0, c);
      v = 8'($urandom);
      acc(1'b1, c, OFF_DATA, v);
      tick(2);
      chk("tx_data", txd[c], v);
      tick(8);
      see_irq(1'b1, c);
      acc(1'b1, c, OFF_IER, 8'h01);
      byte_req <= 4'h1 << c;
      tick(1);
      byte_req <= '0;
      see_irq(1'b1, c);
      acc(1'b0, c, OFF_IIR, 8'h00);
      chk("iir_rx", q, {4'h0, IIR_RXA});
      acc(1'b0, c, OFF_DATA, 8'h00);
      chk("rx_byte", q, 8'(8'hC0 + c));
      see_irq(1'b0, c);
      acc(1'b1, c, OFF_IER, 8'h04);
      err_req <= 4'h1 << c;
      tick(1);
      err_req <= '0;
      see_irq(1'b1, c);
      acc(1'b0, c, OFF_IIR, 8'h00);
      chk("iir_err", q, {4'h0, IIR_LSR});
      acc(1'b0, c, OFF_LSR, 8'h00);
      chk("lsr_err", q & 8'h02, 8'h02);
      see_irq(1'b0, c);
      acc(1'b1, c, OFF_IER, 8'h08);
      ready <= ready | (4'h1 << c);
      see_irq(1'b1, c);
      acc(1'b0, c, OFF_MSR, 8'h00);
      chk("msr", q, 8'h22);
      see_irq(1'b0, c);
      chk("tx_idle", {4'h0, tx}, 8'h0F);
      acc(1'b1, c, OFF_IER, 8'h00);
    end
    // Each channel kept its own scratch value while the others were written.
    for (int c = 0; c < NCH; c++) begin
      acc(1'b0, c, OFF_SCR, 8'h00);
      chk("scratch_keep", q, scr[c]);
    end
    acc(1'b1, 0, OFF_MCTL, 8'h09);
    acc(1'b1, 0, OFF_IER, 8'h02);
    tick(4);
    rst_n <= 1'b0;
    tick(2);
    chk("rerun_pins", {dtr_n, oe_n}, 8'hFF);
    chk("rerun_irq", {4'h0, irq}, 8'h00);
    rst_n <= 1'b1;
    acc(1'b0, 0, OFF_SCR, 8'h00);
    chk("scratch_rst", q, REG_RST);
    wrap_up();
  end
endmodule
